// ---- psfs_pkg.sv ----
// Package for the sequencing and fault supervisor: timing, flag layout, states
package psfs_pkg;
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned GOOD_DELAY_US = 1000;
  localparam int unsigned GOOD_DELAY_CYC = (CLK_HZ / 1_000_000) * GOOD_DELAY_US;
  localparam int unsigned FLAG_W        = 13;
  // Flag bit positions
  localparam int unsigned F_UV5    = 0;
  localparam int unsigned F_IN12_UNDERVOLT_FLAG   = 1;
  localparam int unsigned F_FUSE12_OVERCURRENT_FLAG   = 2;
  localparam int unsigned F_OC5    = 3;
  localparam int unsigned F_REG_0V9_OVERCURRENT_FLAG   = 4;
  localparam int unsigned F_REG_3V3_OVERCURRENT_FLAG   = 5;
  localparam int unsigned F_REG_0V9_UNDERVOLT_FLAG   = 6;
  localparam int unsigned F_REG_3V3_UNDERVOLT_FLAG   = 7;
  localparam int unsigned F_TW12   = 8;
  localparam int unsigned F_TW5    = 9;
  localparam int unsigned F_TW09   = 10;
  localparam int unsigned F_OT5    = 11;
  localparam int unsigned F_FUSE12_OVERTEMP_FLAG   = 12;
  localparam logic [12:0] FLAGS_RST = 13'h0000;

  typedef enum logic [1:0] {PSFS_OFF, PSFS_RAMP, PSFS_ON} psfs_fuse_type;

  // Raw analog comparator and monitor inputs
  typedef struct packed {
    logic in5_above_uv;
    logic in12_above_uv;
    logic rail_above_uv;
    logic rail_above_2v5;
    logic out33_good;
    logic out09_good;
    logic fuse12_overcurrent_flag;
    logic oc5;
    logic reg_0v9_overcurrent_flag;
    logic reg_3v3_overcurrent_flag;
    logic tw12;
    logic tw5;
    logic tw09;
    logic fuse12_overtemp_flag;
    logic ot5;
    logic ot09;
    logic en09;
    logic pdis;
  } psfs_sense_type;
  localparam int unsigned SENSE_W = 18;
endpackage : psfs_pkg

// ---- psfs_supervisor.sv ----
// Power sequencing and fault supervisor logic
// Overview of operation
// - 5 V input above undervoltage threshold starts 5 V e-fuse ramp
// - 12 V input above threshold ramps 12 V e-fuse, independently of 5 V
// - 3.3 V regulator starts by itself once supply rail exceeds turn-on level
// - 3.3 V good output rises 1 ms after output last seen good
// - 0.9 V regulator stays off until enable pin high, starts afterwards
// - 0.9 V good output rises 1 ms after output last seen good
// - Input undervoltage opens its fuse only, interrupts, latches flag, regulators stay
// - Both inputs failed opens both fuses, logic continues from supply rail
// - No control turns off 3.3 V regulator while its rail is present
// - Force bit holds 3.3 V low-side switch on continuously, no switching
// - 0.9 V output undervoltage drops its good, interrupts, latches flag, stays enabled
// - 3.3 V output undervoltage drops its good, interrupts, latches flag, stays enabled
// - Overcurrent keeps output limited, interrupts, latches flag; ignored during ramp
// - 12 V warning only flags; 12 V overtemperature also opens 12 V fuse
// - 5 V warning only flags; 5 V overtemperature also opens 5 V fuse
// - 0.9 V warning flags; 0.9 V overtemperature sets both fuse overtemp flags
// - Rail below 2.5 V disables regulators, drops goods, no interrupt, no flag
// - Enabled power-disable pin high opens fuses, interrupts; state flag follows pin
`timescale 1ns/1ps
module psfs_supervisor #(
  parameter int unsigned GOOD_DELAY = psfs_pkg::GOOD_DELAY_CYC
) (
  input  wire logic                          clk_sys_i,
  input  wire logic                          nrst_i,
  input  wire logic [psfs_pkg::SENSE_W-1:0]  sense_i,
  input  wire logic                          pdis_feature_en_i,
  input  wire logic                          reg_3v3_force_lowside_i,
  input  wire logic [psfs_pkg::FLAG_W-1:0]   flag_clear_i,
  output logic                               fuse5_close_o,
  output logic                               fuse12_close_o,
  output logic                               fuse5_ramping_o,
  output logic                               fuse12_ramping_o,
  output logic                               reg_3v3_enable_o,
  output logic                               reg_3v3_lowside_hold_o,
  output logic                               reg_0v9_enable_o,
  output logic                               good_3v3_o,
  output logic                               good_0v9_o,
  output logic                               fault_irq_n_o,
  output logic [psfs_pkg::FLAG_W-1:0]        status_flags_o,
  output logic                               power_disable_state_flag_o
);
  localparam int unsigned CW = $clog2(GOOD_DELAY + 1);
  localparam logic [CW-1:0] GOOD_LAST = CW'(GOOD_DELAY - 1);

  // Three-stage synchroniser; first stage read only by second
  logic [psfs_pkg::SENSE_W-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      filt_q <= '0;
    end else begin
      s1_q   <= sense_i;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
    end
  end
  // Change counts once stages two and three agree
  assign filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));

  psfs_pkg::psfs_sense_type sn;
  assign sn = psfs_pkg::psfs_sense_type'(filt_q);

  wire pdis_active = pdis_feature_en_i & sn.pdis;
  wire rail_ok     = sn.rail_above_2v5 & sn.rail_above_uv;

  // E-fuse state machines
  psfs_pkg::psfs_fuse_type f5_q, f5_d, f12_q, f12_d;
  logic ot5_open_q, fuse12_overtemp_flag_open_q;
  wire f5_allow  = sn.in5_above_uv & ~ot5_open_q & ~pdis_active;
  wire f12_allow = sn.in12_above_uv & ~fuse12_overtemp_flag_open_q & ~pdis_active;

  // Ramp ends when the fuse leaves current limit
  always_comb begin
    f5_d = f5_q;
    unique case (f5_q)
      psfs_pkg::PSFS_OFF:  if (f5_allow) f5_d = psfs_pkg::PSFS_RAMP;
      psfs_pkg::PSFS_RAMP: if (!f5_allow) f5_d = psfs_pkg::PSFS_OFF;
                           else if (!sn.oc5) f5_d = psfs_pkg::PSFS_ON;
      psfs_pkg::PSFS_ON:   if (!f5_allow) f5_d = psfs_pkg::PSFS_OFF;
    endcase
  end
  always_comb begin
    f12_d = f12_q;
    unique case (f12_q)
      psfs_pkg::PSFS_OFF:  if (f12_allow) f12_d = psfs_pkg::PSFS_RAMP;
      psfs_pkg::PSFS_RAMP: if (!f12_allow) f12_d = psfs_pkg::PSFS_OFF;
                           else if (!sn.fuse12_overcurrent_flag) f12_d = psfs_pkg::PSFS_ON;
      psfs_pkg::PSFS_ON:   if (!f12_allow) f12_d = psfs_pkg::PSFS_OFF;
    endcase
  end

  // Overtemperature open holds until the die cools below threshold
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      f5_q        <= psfs_pkg::PSFS_OFF;
      f12_q       <= psfs_pkg::PSFS_OFF;
      ot5_open_q  <= 1'b0;
      fuse12_overtemp_flag_open_q <= 1'b0;
    end else begin
      f5_q        <= f5_d;
      f12_q       <= f12_d;
      ot5_open_q  <= sn.ot5;
      fuse12_overtemp_flag_open_q <= sn.fuse12_overtemp_flag;
    end
  end

  // Regulators: 3.3 V has no off control; only rail loss stops it
  logic r33_en_q, r09_en_q, r33_ramp_q, r09_ramp_q;
  wire r33_en_d = rail_ok;
  wire r09_en_d = rail_ok & sn.en09;
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      r33_en_q   <= 1'b0;
      r09_en_q   <= 1'b0;
      r33_ramp_q <= 1'b0;
      r09_ramp_q <= 1'b0;
    end else begin
      r33_en_q   <= r33_en_d;
      r09_en_q   <= r09_en_d;
      r33_ramp_q <= r33_en_d & (r33_ramp_q | ~r33_en_q) & ~sn.out33_good;
      r09_ramp_q <= r09_en_d & (r09_ramp_q | ~r09_en_q) & ~sn.out09_good;
    end
  end

  // Good delay counters restart on every drop below threshold
  logic [CW-1:0] c33_q, c09_q;
  logic g33_q, g09_q, was33_q, was09_q;
  // Qualified by this cycle's enable too, so a rail loss drops good with the enable
  wire ok33 = r33_en_q & r33_en_d & sn.out33_good;
  wire ok09 = r09_en_q & r09_en_d & sn.out09_good;
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      c33_q   <= '0;
      c09_q   <= '0;
      g33_q   <= 1'b0;
      g09_q   <= 1'b0;
      was33_q <= 1'b0;
      was09_q <= 1'b0;
    end else begin
      c33_q   <= !ok33 ? '0 : (c33_q == GOOD_LAST ? c33_q : c33_q + 1'b1);
      c09_q   <= !ok09 ? '0 : (c09_q == GOOD_LAST ? c09_q : c09_q + 1'b1);
      g33_q   <= ok33 & (c33_q == GOOD_LAST);
      g09_q   <= ok09 & (c09_q == GOOD_LAST);
      was33_q <= g33_q;
      was09_q <= g09_q;
    end
  end

  // Undervoltage of an output only counts once it had been good
  wire reg_3v3_undervolt_flag_evt = was33_q & ~sn.out33_good & rail_ok;
  wire reg_0v9_undervolt_flag_evt = was09_q & ~sn.out09_good & rail_ok;

  logic [psfs_pkg::FLAG_W-1:0] ev, flags_q;
  logic in5_seen_q, in12_seen_q;
  always_comb begin
    ev = '0;
    ev[psfs_pkg::F_UV5]  = in5_seen_q & ~sn.in5_above_uv;
    ev[psfs_pkg::F_IN12_UNDERVOLT_FLAG] = in12_seen_q & ~sn.in12_above_uv;
    ev[psfs_pkg::F_FUSE12_OVERCURRENT_FLAG] = sn.fuse12_overcurrent_flag & (f12_q == psfs_pkg::PSFS_ON);
    ev[psfs_pkg::F_OC5]  = sn.oc5 & (f5_q == psfs_pkg::PSFS_ON);
    ev[psfs_pkg::F_REG_0V9_OVERCURRENT_FLAG] = sn.reg_0v9_overcurrent_flag & r09_en_q & ~r09_ramp_q;
    ev[psfs_pkg::F_REG_3V3_OVERCURRENT_FLAG] = sn.reg_3v3_overcurrent_flag & r33_en_q & ~r33_ramp_q;
    ev[psfs_pkg::F_REG_0V9_UNDERVOLT_FLAG] = reg_0v9_undervolt_flag_evt;
    ev[psfs_pkg::F_REG_3V3_UNDERVOLT_FLAG] = reg_3v3_undervolt_flag_evt;
    ev[psfs_pkg::F_TW12] = sn.tw12;
    ev[psfs_pkg::F_TW5]  = sn.tw5;
    ev[psfs_pkg::F_TW09] = sn.tw09;
    ev[psfs_pkg::F_OT5]  = sn.ot5 | sn.ot09;
    ev[psfs_pkg::F_FUSE12_OVERTEMP_FLAG] = sn.fuse12_overtemp_flag | sn.ot09;
  end

  // Set wins over a clear in the same cycle
  wire [psfs_pkg::FLAG_W-1:0] flags_d = ev | (flags_q & ~flag_clear_i);
  logic irq_n_q, pdis_q;
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      flags_q     <= psfs_pkg::FLAGS_RST;
      in5_seen_q  <= 1'b0;
      in12_seen_q <= 1'b0;
      irq_n_q     <= 1'b1;
      pdis_q      <= 1'b0;
    end else begin
      flags_q     <= flags_d;
      in5_seen_q  <= sn.in5_above_uv;
      in12_seen_q <= sn.in12_above_uv;
      irq_n_q     <= ~(|flags_d | pdis_active);
      pdis_q      <= sn.pdis;
    end
  end

  assign fuse5_close_o              = (f5_q != psfs_pkg::PSFS_OFF);
  assign fuse12_close_o             = (f12_q != psfs_pkg::PSFS_OFF);
  assign fuse5_ramping_o            = (f5_q == psfs_pkg::PSFS_RAMP);
  assign fuse12_ramping_o           = (f12_q == psfs_pkg::PSFS_RAMP);
  assign reg_3v3_enable_o           = r33_en_q;
  // Parked regulator: low side held on, grounding the switch node
  assign reg_3v3_lowside_hold_o     = r33_en_q & reg_3v3_force_lowside_i;
  assign reg_0v9_enable_o           = r09_en_q;
  assign good_3v3_o                 = g33_q;
  assign good_0v9_o                 = g09_q;
  assign fault_irq_n_o              = irq_n_q;
  assign status_flags_o             = flags_q;
  assign power_disable_state_flag_o = pdis_q;

  // Named steps used by the checks below
  sequence s_fuse5_start;
    (f5_q == psfs_pkg::PSFS_OFF) && f5_allow;
  endsequence
  sequence s_fuse12_start;
    (f12_q == psfs_pkg::PSFS_OFF) && f12_allow;
  endsequence
  sequence s_fuse5_limit;
    sn.oc5 && (f5_q == psfs_pkg::PSFS_ON) && f5_allow;
  endsequence
  sequence s_fuse12_limit;
    sn.fuse12_overcurrent_flag && (f12_q == psfs_pkg::PSFS_ON) && f12_allow;
  endsequence
  sequence s_in5_lost;
    in5_seen_q && !sn.in5_above_uv;
  endsequence
  sequence s_in12_lost;
    in12_seen_q && !sn.in12_above_uv;
  endsequence
  sequence s_both_lost;
    !sn.in5_above_uv && !sn.in12_above_uv && rail_ok;
  endsequence
  sequence s_good33_rose;
    $rose(good_3v3_o);
  endsequence
  sequence s_good09_rose;
    $rose(good_0v9_o);
  endsequence

  // Start-up order, input loss and 3.3 V low-side hold
  a_fuse5_start: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    s_fuse5_start |=> fuse5_ramping_o)
    else $error("5v fuse did not start ramp");
  a_fuse12_start: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    s_fuse12_start |=> fuse12_ramping_o)
    else $error("12v fuse did not start ramp");
  a_r33_auto: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    rail_ok |=> reg_3v3_enable_o)
    else $error("3v3 did not start");
  a_good33_rise: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    s_good33_rose |-> $past(c33_q) == GOOD_LAST && $past(ok33))
    else $error("3v3 good rose early");
  a_en09_gate: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !sn.en09 |=> !reg_0v9_enable_o)
    else $error("0v9 enabled without pin");
  a_reg09_start: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    rail_ok && sn.en09 |=> reg_0v9_enable_o)
    else $error("0v9 did not start");
  a_good09_rise: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    s_good09_rose |-> $past(c09_q) == GOOD_LAST && $past(ok09))
    else $error("0v9 good rose early");
  a_uv5_open: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    s_in5_lost |=> !fuse5_close_o && flags_q[psfs_pkg::F_UV5] && !fault_irq_n_o)
    else $error("5v input loss not handled");
  a_in12_undervolt_flag_open: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    s_in12_lost |=> !fuse12_close_o && flags_q[psfs_pkg::F_IN12_UNDERVOLT_FLAG] && !fault_irq_n_o)
    else $error("12v input loss not handled");
  a_uv_regs_on: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !sn.in5_above_uv && rail_ok |=> reg_3v3_enable_o)
    else $error("input loss stopped 3v3");
  a_both_open: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    s_both_lost |=> !fuse5_close_o && !fuse12_close_o && reg_3v3_enable_o)
    else $error("both inputs lost not handled");
  a_lowside_en: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    reg_3v3_lowside_hold_o |-> reg_3v3_enable_o)
    else $error("low side held while 3v3 off");
  a_lowside_park: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    reg_3v3_force_lowside_i && reg_3v3_enable_o |-> reg_3v3_lowside_hold_o)
    else $error("parked 3v3 low side not held");

  // Fault reactions
  a_good09_drop: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !sn.out09_good |=> !good_0v9_o)
    else $error("0v9 good not dropped");
  a_reg_0v9_undervolt_flag_flag: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    reg_0v9_undervolt_flag_evt |=> flags_q[psfs_pkg::F_REG_0V9_UNDERVOLT_FLAG] && !fault_irq_n_o)
    else $error("0v9 undervoltage not flagged");
  a_reg_0v9_undervolt_flag_keep: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    reg_0v9_undervolt_flag_evt && sn.en09 |=> reg_0v9_enable_o)
    else $error("0v9 disabled in recovery");
  a_good33_drop: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !sn.out33_good |=> !good_3v3_o)
    else $error("3v3 good not dropped");
  a_reg_3v3_undervolt_flag_flag: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    reg_3v3_undervolt_flag_evt |=> flags_q[psfs_pkg::F_REG_3V3_UNDERVOLT_FLAG] && !fault_irq_n_o && reg_3v3_enable_o)
    else $error("3v3 undervoltage not handled");
  a_oc5_flag: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    s_fuse5_limit |=> fuse5_close_o && flags_q[psfs_pkg::F_OC5] && !fault_irq_n_o)
    else $error("5v overcurrent not handled");
  a_fuse12_overcurrent_flag_flag: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    s_fuse12_limit |=> fuse12_close_o && flags_q[psfs_pkg::F_FUSE12_OVERCURRENT_FLAG] && !fault_irq_n_o)
    else $error("12v overcurrent not handled");
  a_ramp_oc_quiet: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    fuse5_ramping_o && !flags_q[psfs_pkg::F_OC5] |=> !flags_q[psfs_pkg::F_OC5])
    else $error("ramp current limit flagged");
  a_reg_3v3_overcurrent_flag_flag: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    sn.reg_3v3_overcurrent_flag && r33_en_q && !r33_ramp_q |=> flags_q[psfs_pkg::F_REG_3V3_OVERCURRENT_FLAG] && !fault_irq_n_o)
    else $error("3v3 overcurrent not flagged");
  a_reg_0v9_overcurrent_flag_flag: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    sn.reg_0v9_overcurrent_flag && r09_en_q && !r09_ramp_q |=> flags_q[psfs_pkg::F_REG_0V9_OVERCURRENT_FLAG] && !fault_irq_n_o)
    else $error("0v9 overcurrent not flagged");
  a_tw12_only: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    sn.tw12 && f12_allow |=> fuse12_close_o && flags_q[psfs_pkg::F_TW12] && !fault_irq_n_o)
    else $error("12v warning not handled");
  a_fuse12_overtemp_flag_open: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    fuse12_overtemp_flag_open_q |=> !fuse12_close_o)
    else $error("12v fuse closed in overtemp");
  a_ot5_open: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ot5_open_q |=> !fuse5_close_o)
    else $error("5v fuse closed in overtemp");
  a_tw5_only: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    sn.tw5 && f5_allow |=> fuse5_close_o && flags_q[psfs_pkg::F_TW5] && !fault_irq_n_o)
    else $error("5v warning not handled");
  a_tw09_flag: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    sn.tw09 |=> flags_q[psfs_pkg::F_TW09] && !fault_irq_n_o)
    else $error("0v9 warning not flagged");
  a_ot09_both: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    sn.ot09 |=> flags_q[psfs_pkg::F_OT5] && flags_q[psfs_pkg::F_FUSE12_OVERTEMP_FLAG])
    else $error("0v9 overtemp flags missing");
  a_ot09_keep: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    sn.ot09 && f5_allow && f12_allow |=> fuse5_close_o && fuse12_close_o)
    else $error("0v9 overtemp opened a fuse");
  a_rail_loss_off: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !rail_ok |=> !reg_3v3_enable_o && !reg_0v9_enable_o && !good_3v3_o && !good_0v9_o)
    else $error("rail loss did not stop regulators");
  a_pdis_open: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    pdis_active |=> !fuse5_close_o && !fuse12_close_o && !fault_irq_n_o)
    else $error("power disable did not open fuses");
  a_pdis_state: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    power_disable_state_flag_o == $past(sn.pdis))
    else $error("power disable state off pin");
  a_flag_sticky: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (flags_q[psfs_pkg::F_OC5] && !flag_clear_i[psfs_pkg::F_OC5]) |=> flags_q[psfs_pkg::F_OC5])
    else $error("flag lost without clear");
  a_irq_follow: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (|flags_q) |-> !fault_irq_n_o)
    else $error("flag set without interrupt");
endmodule : psfs_supervisor

// ---- psfs_host_model.sv ----
// Host processor model: parks the 3.3 V regulator and clears latched status
`timescale 1ns/1ps
module psfs_host_model (
  input  wire logic        clk_sys_i,
  input  wire logic        fault_irq_n_i,
  input  wire logic [12:0] status_flags_i,
  input  wire logic        clear_req_i,
  input  wire logic        force_req_i,
  output logic      [12:0] flag_clear_o,
  output logic             force_o
);
  // Force bit written before the 0.9 V enable is raised
  always_ff @(posedge clk_sys_i) force_o <= force_req_i;
  // Only clears what it read, and only while interrupted
  always_ff @(posedge clk_sys_i) begin
    flag_clear_o <= (clear_req_i && !fault_irq_n_i) ? status_flags_i : 13'h0000;
  end
endmodule : psfs_host_model

// ---- tb.sv ----
// Self-checking bench for the sequencing and fault supervisor
`timescale 1ns/1ps
module tb;
  localparam int GD = 8;
  localparam int SBIT [18] = '{17, 16, 11, 10, 9, 8, 12, 13, 7, 6, 5, 3, 4, 2, 0, 0, 14, 17};
  localparam int FBIT [13] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12};
  localparam logic [17:0] BASE = 18'h3f002;
  logic        clk_sys_i;
  logic        nrst_i;
  logic [17:0] sense;
  logic        pdis_en;
  logic [12:0] clr;
  logic        clr_req;
  logic        force_req;
  logic        force_bit;
  logic        f5, f12, r5, r12, en33, hold, en09, g33, g09, irq_n, pds;
  logic [12:0] flags;
  int          n_mismatch;
  int          checks;
  int          e;

  psfs_supervisor #(.GOOD_DELAY(GD)) i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sense_i(sense),
    .pdis_feature_en_i(pdis_en), .reg_3v3_force_lowside_i(force_bit), .flag_clear_i(clr),
    .fuse5_close_o(f5), .fuse12_close_o(f12), .fuse5_ramping_o(r5), .fuse12_ramping_o(r12),
    .reg_3v3_enable_o(en33), .reg_3v3_lowside_hold_o(hold), .reg_0v9_enable_o(en09),
    .good_3v3_o(g33), .good_0v9_o(g09), .fault_irq_n_o(irq_n), .status_flags_o(flags),
    .power_disable_state_flag_o(pds));

  psfs_host_model i_host (.clk_sys_i(clk_sys_i), .fault_irq_n_i(irq_n), .status_flags_i(flags),
    .clear_req_i(clr_req), .force_req_i(force_req), .flag_clear_o(clr), .force_o(force_bit));

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick

  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t bit got %b exp %b event %0d", $time, got, exp, e);
    end
  endtask : chk1

  task automatic chkf(input logic [12:0] got, input logic [12:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t flags got %h exp %h event %0d", $time, got, exp, e);
    end
  endtask : chkf

  // Expected sticky flags for each injected event
  function automatic logic [12:0] exp_flags(input int ev);
    logic [12:0] f;
    f = 13'h0000;
    if (ev < 13) f[FBIT[ev]] = 1'b1;
    if (ev == 13) f = (13'h0001 << psfs_pkg::F_OT5) | (13'h0001 << psfs_pkg::F_FUSE12_OVERTEMP_FLAG);
    if (ev == 17) f = (13'h0001 << psfs_pkg::F_UV5) | (13'h0001 << psfs_pkg::F_IN12_UNDERVOLT_FLAG);
    return f;
  endfunction : exp_flags

  task automatic finish_test;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  initial begin
    #100000;
    n_mismatch++;
    $display("[ERR] %0t run did not complete", $time);
    finish_test;
  end

  initial begin
    nrst_i = 1'b0;
    sense = 18'h00000;
    pdis_en = 1'b1;
    clr_req = 1'b0;
    force_req = 1'b0;
    n_mismatch = 0;
    checks = 0;
    e = -1;
    void'($urandom(44));
    tick(20);
    chk1(irq_n, 1'b1);
    chkf(flags, 13'h0000);
    nrst_i = 1'b1;
    tick(2);
    chk1(f5, 1'b0);
    // Start-up with oc5 and fuse12_overcurrent_flag held: ramp current limit is not a fault
    sense = BASE & ~18'h00002 | 18'h00c00;
    tick(6);
    chk1(r5, 1'b1);
    chk1(f12, 1'b1);
    chk1(r12, 1'b1);
    chkf(flags, 13'h0000);
    chk1(en33, 1'b1);
    chk1(en09, 1'b0);
    chk1(g33, 1'b0);
    force_req = 1'b1;
    tick(2);
    chk1(hold, 1'b1);
    sense = BASE;
    tick(6);
    chk1(r5, 1'b0);
    chk1(r12, 1'b0);
    chk1(en09, 1'b1);
    chk1(g09, 1'b0);
    force_req = 1'b0;
    tick(GD + 8);
    chk1(g33, 1'b1);
    chk1(g09, 1'b1);
    chk1(hold, 1'b0);
    for (int i = 0; i < 36; i++) begin
      e = (i < 18) ? i : int'($urandom_range(0, 17));
      pdis_en = (e != 15);
      sense = BASE ^ (18'h00001 << SBIT[e]);
      if (e == 17) sense[16] = 1'b0;
      tick(6);
      chk1(irq_n, e == 15 || e == 16);
      chkf(flags, exp_flags(e));
      chk1(f5, !(e inside {0, 11, 14, 17}));
      chk1(f12, !(e inside {1, 12, 14, 17}));
      chk1(en33, e != 16);
      chk1(en09, e != 16);
      chk1(g33, !(e inside {7, 16}));
      chk1(g09, !(e inside {6, 16}));
      chk1(pds, e == 14 || e == 15);
      sense = BASE;
      pdis_en = 1'b1;
      tick(6);
      chkf(flags, exp_flags(e));
      clr_req = 1'b1;
      tick(1);
      clr_req = 1'b0;
      tick(4);
      chkf(flags, 13'h0000);
      chk1(irq_n, 1'b1);
      tick(GD + 12);
    end
    finish_test;
  end
endmodule : tb
